// ===== bus_partner.sv
// Far-side model: host hold responder, upper-address latch and a byte memory.
// Assumes it shares the core's clock and sees the core's pins directly.
`timescale 1ns/1ps
module bus_partner (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] lag_in,
  input wire logic hold_request_in,
  output logic hold_acknowledge_out,
  input wire logic upper_addr_strobe_in,
  input wire logic [7:0] data_bus_in,
  input wire logic [7:0] addr_low_in,
  input wire logic mem_write_b_in,
  input wire logic [3:0] ack_in,
  output logic [7:0] mem_data_out,
  output logic [15:0] strobes_out,
  output logic [15:0] writes_out,
  output logic [15:0] last_addr_out,
  output logic [7:0] last_data_out,
  output logic [3:0] first_ack_out
);
  logic [7:0] upper;
  logic [3:0] wait_cnt;
  logic upper_addr_strobe_q;
  logic wr_q;
  logic [3:0] ack_q;
  // Source bytes differ per address so a fixed source shows up
  assign mem_data_out = addr_low_in ^ 8'h5A;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      {hold_acknowledge_out, upper, wait_cnt, upper_addr_strobe_q, wr_q, ack_q} <= '0;
      {strobes_out, writes_out, last_addr_out, last_data_out, first_ack_out} <= '0;
    end
    else
    begin
      // Host grants after a variable lag and takes the bus back on release
      wait_cnt <= hold_request_in ? wait_cnt + 4'(wait_cnt != lag_in) : 4'h0;
      hold_acknowledge_out <= hold_request_in && wait_cnt == lag_in;
      upper_addr_strobe_q <= upper_addr_strobe_in;
      wr_q <= mem_write_b_in;
      ack_q <= ack_in;
      if (upper_addr_strobe_in)
        upper <= data_bus_in;
      if (upper_addr_strobe_in && !upper_addr_strobe_q)
        strobes_out <= strobes_out + 16'h0001;
      if (!mem_write_b_in && wr_q)
      begin
        writes_out <= writes_out + 16'h0001;
        last_addr_out <= {upper, addr_low_in};
        last_data_out <= data_bus_in;
      end
      if (ack_in != 4'h0 && ack_q == 4'h0)
        first_ack_out <= ack_in;
    end
endmodule

// ===== dma_core_chk.sv
// Port-level assertions for the DMA transfer core.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module dma_core_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic data_oe_out,
  input wire logic io_read_strobe_b_out,
  input wire logic io_read_strobe_oe_out,
  input wire logic io_write_strobe_b_out,
  input wire logic io_write_strobe_oe_out,
  input wire logic mem_read_strobe_b_out,
  input wire logic mem_write_strobe_b_out,
  input wire logic addr_low_oe_out,
  input wire logic addr_enable_out,
  input wire logic upper_addr_strobe_out,
  input wire logic [3:0] channel_acknowledge_out,
  input wire logic hold_request_out,
  input wire logic hold_acknowledge_in,
  input wire logic end_of_process_oe_out,
  input wire logic terminal_count_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_write_pair: assert property (
    !mem_write_strobe_b_out && channel_acknowledge_out != 4'h0
    |-> !io_read_strobe_b_out && io_read_strobe_oe_out)
    else $error("memory write without io read");
  chk_read_pair: assert property (
    io_write_strobe_oe_out && !io_write_strobe_b_out |-> !mem_read_strobe_b_out)
    else $error("io write without memory read");
  chk_strobe_idle: assert property (
    !addr_enable_out |-> mem_read_strobe_b_out && mem_write_strobe_b_out)
    else $error("memory strobe outside service");
  chk_upper_pulse: assert property (
    $rose(upper_addr_strobe_out) |=> !upper_addr_strobe_out)
    else $error("upper strobe longer than one cycle");
  chk_upper_drive: assert property (
    upper_addr_strobe_out |-> addr_enable_out && data_oe_out && addr_low_oe_out)
    else $error("upper state without address drive");
  chk_ack_onehot: assert property (
    channel_acknowledge_out != 4'h0 |-> $onehot(channel_acknowledge_out) && addr_enable_out)
    else $error("acknowledge not one-hot");
  chk_ack_stays: assert property (
    channel_acknowledge_out != 4'h0 ##1 channel_acknowledge_out != 4'h0
    |-> $stable(channel_acknowledge_out))
    else $error("running channel pre-empted");
  chk_service_grant: assert property (
    $rose(addr_enable_out) |-> hold_request_out && hold_acknowledge_in)
    else $error("service started without hold handshake");
  chk_tc_end: assert property (
    terminal_count_out |-> end_of_process_oe_out && !hold_request_out ##1 !terminal_count_out)
    else $error("terminal count pulse malformed");
  cover property (terminal_count_out);
  cover property (upper_addr_strobe_out && channel_acknowledge_out == 4'h0);
  cover property (!mem_write_strobe_b_out && channel_acknowledge_out != 4'h0);
endmodule

// ===== dma_core_pkg.sv
// Shared constants, state codes and the state record of the DMA transfer core.
// Assumes one 100 MHz clock and the byte-wide program bus of the controller.
package dma_core_pkg;
  // Program-bus register offsets on the four address pins
  localparam logic [3:0] OFS_COMMAND = 4'h8;
  localparam logic [3:0] OFS_REQUEST = 4'h9;
  localparam logic [3:0] OFS_SINGLE_MASK = 4'hA;
  localparam logic [3:0] OFS_MODE = 4'hB;
  localparam logic [3:0] OFS_CLEAR_PTR = 4'hC;
  localparam logic [3:0] OFS_MASTER_CLEAR = 4'hD;
  localparam logic [3:0] OFS_TEMP_READ = 4'hD;
  localparam logic [3:0] OFS_ALL_MASK = 4'hF;
  // Command bit positions
  localparam int CMD_MEM2MEM = 0;
  localparam int CMD_HOLD_SRC = 1;
  localparam int CMD_DISABLE = 2;
  localparam int CMD_COMPRESS = 3;
  localparam int CMD_ROTATE = 4;
  // Mode field layout, stored from data bits 7..2
  localparam int MODE_AUTOINIT = 2;
  localparam int MODE_DECREMENT = 3;
  localparam logic [1:0] TYPE_VERIFY = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_READ = 2'h2;
  localparam logic [1:0] SERVICE_BLOCK = 2'h2;
  // Synchroniser vector layout
  localparam int SY_CS = 4;
  localparam int SY_IOR = 5;
  localparam int SY_IOW = 6;
  localparam int SY_HOLD_ACKNOWLEDGE = 7;
  localparam int SY_EOP = 8;
  localparam int SY_ADDR = 9;
  // Reset values
  localparam logic [7:0] COMMAND_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [3:0] REQUEST_RST = 4'h0;
  localparam logic [1:0] LAST_RST = 2'h3;
  localparam logic [12:0] SYNC_RST = 13'h0170;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_UPPER = 3'b010,
    ST_ADDR = 3'b011,
    ST_EXTEND = 3'b100,
    ST_XFER = 3'b101
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [3:0][15:0] cur_addr;
    logic [3:0][15:0] cur_cnt;
    logic [3:0][15:0] base_addr;
    logic [3:0][15:0] base_cnt;
    logic [7:0] command;
    logic [3:0][5:0] mode;
    logic [3:0] request;
    logic [3:0] mask;
    logic [7:0] temp;
    logic byte_ptr;
    logic [1:0] chan;
    logic [1:0] last;
    logic m2m;
    logic half;
    logic wait_cnt;
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [12:0] prev;
    logic [7:0] din1;
    logic [7:0] din2;
    logic hold_req;
    logic [3:0] channel_acknowledge;
    logic mem_rd_b;
    logic mem_wr_b;
    logic io_rd_b;
    logic io_wr_b;
    logic io_oe;
    logic addr_enable;
    logic upper_addr_strobe;
    logic [7:0] addr_lo;
    logic addr_oe;
    logic [7:0] dout;
    logic dout_oe;
    logic eop_level;
    logic eop_drive;
    logic tc;
  } core_s;
endpackage

// ===== four_channel_dma_transfer_core.sv
// Transfer engine and channel register set of a four-channel DMA controller.
// Assumes an external upper-address latch, a host hold handshake and
// pin-level strobes resolved to wires by the surroundings.
//
// Function
// - Write moves I/O to memory with io read and memory write strobes; read the reverse.
// - Verify sequences like read or write but keeps every read and write strobe inactive.
// - With mem2mem_enable, channel 0 gives source and channel 1 destination address.
// - Memory moves end on channel 1 count and start from channel 0 software request.
// - Fixed channel 0 source address writes one byte over the whole destination.
// - No acknowledge during memory moves; external end_of_process still ends them.
// - Autoinitialize reloads current from base after end_of_process, mask untouched.
// - Base registers written with current ones, held during service, never readable.
// - A write is taken only while idle; it overwrites intermediate current values and base values.
// - Fixed priority: channel 0 highest, then 1, 2, channel 3 lowest.
// - Rotating priority: last serviced becomes lowest, others rotate.
// - Pick winner on rising hold_acknowledge; no pre-emption of a running channel.
// - Compressed timing drops the read-extension state except on memory-move reads: two clocks per I/O transfer.
// - Upper-address state drives bits 15..8 on data, strobe latches, low bits direct.
// - Upper-address state runs at service start, for each memory-move half, and when the address crosses bit 7 to bit 8.
// - Current address steps each transfer; processor accesses it as two bytes.
// - Count holds transfers minus one, decrements, terminal_count at the end.
// - Internal end without autoinitialize leaves the count reading all ones.
// - Command register written only while programming, cleared by reset.
// - Six-bit mode per channel; data bits 0 and 1 choose the channel.
// - Software request bits set or cleared singly, cleared at end, block mode only.
// - Byte pointer toggles per byte access to a 16-bit register; reset, master clear or command clear it.
// - Mask bit set at end unless autoinitialize; reset sets the whole mask.
`timescale 1ns/1ps
module four_channel_dma_transfer_core
  import dma_core_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic chip_select_b_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic io_read_strobe_b_in,
  output logic io_read_strobe_b_out,
  output logic io_read_strobe_oe_out,
  input wire logic io_write_strobe_b_in,
  output logic io_write_strobe_b_out,
  output logic io_write_strobe_oe_out,
  output logic mem_read_strobe_b_out,
  output logic mem_write_strobe_b_out,
  output logic [7:0] addr_low_out,
  output logic addr_low_oe_out,
  output logic addr_enable_out,
  output logic upper_addr_strobe_out,
  input wire logic [3:0] channel_request_in,
  output logic [3:0] channel_acknowledge_out,
  output logic hold_request_out,
  input wire logic hold_acknowledge_in,
  input wire logic end_of_process_b_in,
  output logic end_of_process_b_out,
  output logic end_of_process_oe_out,
  output logic terminal_count_out
);
  import dma_core_pkg::*;

  core_s s;
  core_s next_s;
  logic program_cond;
  logic wr_done;
  logic rd_done;
  logic ext_end;
  logic hold_acknowledge_rise;
  logic tc_hit;
  logic hold_src;
  logic active;
  logic [3:0] reqs;
  logic [2:0] winner;
  logic [3:0] reg_addr;
  logic [1:0] src;
  logic [1:0] cnt_ch;
  logic [1:0] xtype;
  logic [15:0] next_addr;
  logic [15:0] rd_word;

  function automatic logic [15:0] put_byte(input logic [15:0] v, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  // Returns {found, channel}; rotation starts just after the last serviced channel
  function automatic logic [2:0] pick(input logic [3:0] r, input logic rot,
                                      input logic [1:0] last);
    logic [1:0] idx;
    pick = 3'h0;
    for (int k = 3; k >= 0; k--)
    begin
      idx = rot ? 2'(last + 2'h1 + 2'(k)) : 2'(k);
      if (r[idx])
      begin
        pick = {1'b1, idx};
      end
    end
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.sync1 = {reg_addr_in, end_of_process_b_in, hold_acknowledge_in,
                    io_write_strobe_b_in, io_read_strobe_b_in, chip_select_b_in,
                    channel_request_in};
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.din1 = data_in;
    next_s.din2 = s.din1;
    next_s.tc = 1'b0;
    next_s.eop_drive = 1'b0;
    reg_addr = s.sync2[SY_ADDR +: 4];
    program_cond = (s.phase == ST_IDLE) && !s.sync2[SY_CS] && !s.sync2[SY_HOLD_ACKNOWLEDGE];
    // Commit on the trailing edge of the strobe, when data has long settled
    wr_done = program_cond && s.sync2[SY_IOW] && !s.prev[SY_IOW];
    rd_done = program_cond && s.sync2[SY_IOR] && !s.prev[SY_IOR];
    ext_end = !s.sync2[SY_EOP];
    hold_acknowledge_rise = s.sync2[SY_HOLD_ACKNOWLEDGE] && !s.prev[SY_HOLD_ACKNOWLEDGE];
    for (int i = 0; i < 4; i++)
    begin
      reqs[i] = (s.sync2[i] && !s.mask[i]) ||
                (s.request[i] && (s.mode[i][5:4] == SERVICE_BLOCK));
    end
    if (s.command[CMD_DISABLE])
    begin
      reqs = 4'h0;
    end
    winner = pick(reqs, s.command[CMD_ROTATE], s.last);
    src = s.m2m ? {1'b0, s.half} : s.chan;
    cnt_ch = s.m2m ? 2'h1 : s.chan;
    hold_src = s.m2m && !s.half && s.command[CMD_HOLD_SRC];
    next_addr = s.mode[src][MODE_DECREMENT] ? s.cur_addr[src] - 16'h0001
                                            : s.cur_addr[src] + 16'h0001;
    tc_hit = (s.cur_cnt[cnt_ch] == 16'h0000);
    rd_word = reg_addr[0] ? s.cur_cnt[reg_addr[2:1]] : s.cur_addr[reg_addr[2:1]];

    case (s.phase)
      ST_IDLE:
      begin
        if (wr_done)
        begin
          if (!reg_addr[3])
          begin
            // Base and current load together, even over a paused service
            if (!reg_addr[0])
            begin
              next_s.cur_addr[reg_addr[2:1]] = put_byte(s.cur_addr[reg_addr[2:1]],
                                                        s.byte_ptr, s.din2);
              next_s.base_addr[reg_addr[2:1]] = put_byte(s.base_addr[reg_addr[2:1]],
                                                         s.byte_ptr, s.din2);
            end
            else
            begin
              next_s.cur_cnt[reg_addr[2:1]] = put_byte(s.cur_cnt[reg_addr[2:1]],
                                                       s.byte_ptr, s.din2);
              next_s.base_cnt[reg_addr[2:1]] = put_byte(s.base_cnt[reg_addr[2:1]],
                                                        s.byte_ptr, s.din2);
            end
            next_s.byte_ptr = !s.byte_ptr;
          end
          else
          begin
            case (reg_addr)
              OFS_COMMAND: next_s.command = s.din2;
              OFS_REQUEST: next_s.request[s.din2[1:0]] = s.din2[2];
              OFS_SINGLE_MASK: next_s.mask[s.din2[1:0]] = s.din2[2];
              OFS_MODE: next_s.mode[s.din2[1:0]] = s.din2[7:2];
              OFS_CLEAR_PTR: next_s.byte_ptr = 1'b0;
              OFS_MASTER_CLEAR:
              begin
                next_s.command = COMMAND_RST;
                next_s.request = REQUEST_RST;
                next_s.mask = MASK_RST;
                next_s.temp = 8'h00;
                next_s.byte_ptr = 1'b0;
              end
              OFS_ALL_MASK: next_s.mask = s.din2[3:0];
              default: next_s.mask = s.mask;
            endcase
          end
        end
        if (rd_done && !reg_addr[3])
        begin
          next_s.byte_ptr = !s.byte_ptr;
        end
        if ((|reqs) && !program_cond)
        begin
          next_s.hold_req = 1'b1;
          next_s.phase = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (!(|reqs))
        begin
          next_s.hold_req = 1'b0;
          next_s.phase = ST_IDLE;
        end
        else if (hold_acknowledge_rise)
        begin
          // Winner is fixed here and kept until the bus goes back
          next_s.chan = winner[1:0];
          next_s.m2m = s.command[CMD_MEM2MEM] && (winner[1:0] == 2'h0) &&
                       s.request[0];
          next_s.half = 1'b0;
          next_s.wait_cnt = 1'b0;
          next_s.channel_acknowledge = next_s.m2m ? 4'h0 : 4'(4'h1 << winner[1:0]);
          next_s.phase = ST_UPPER;
        end
      end
      ST_UPPER: next_s.phase = ST_ADDR;
      ST_ADDR:
      begin
        // Memory reads of a block move keep the extension for the data sampler
        next_s.phase = (s.command[CMD_COMPRESS] && !(s.m2m && !s.half)) ?
                       ST_XFER : ST_EXTEND;
      end
      ST_EXTEND: next_s.phase = ST_XFER;
      ST_XFER:
      begin
        if (s.m2m && !s.half && !s.wait_cnt)
        begin
          next_s.wait_cnt = 1'b1;
        end
        else
        begin
          next_s.wait_cnt = 1'b0;
          if (!hold_src)
          begin
            next_s.cur_addr[src] = next_addr;
          end
          if (s.m2m && !s.half)
          begin
            next_s.temp = s.din2;
            next_s.half = 1'b1;
            next_s.phase = ST_UPPER;
          end
          else
          begin
            next_s.cur_cnt[cnt_ch] = s.cur_cnt[cnt_ch] - 16'h0001;
            if (tc_hit || ext_end)
            begin
              for (int i = 0; i < 4; i++)
              begin
                if ((2'(i) == s.chan) || (s.m2m && (i == 1)))
                begin
                  if (s.mode[i][MODE_AUTOINIT])
                  begin
                    next_s.cur_addr[i] = s.base_addr[i];
                    next_s.cur_cnt[i] = s.base_cnt[i];
                  end
                  else
                  begin
                    next_s.mask[i] = 1'b1;
                  end
                  next_s.request[i] = 1'b0;
                end
              end
              next_s.tc = tc_hit;
              next_s.eop_drive = tc_hit;
              next_s.last = s.chan;
              next_s.hold_req = 1'b0;
              next_s.channel_acknowledge = 4'h0;
              next_s.m2m = 1'b0;
              next_s.half = 1'b0;
              next_s.phase = ST_IDLE;
            end
            else if (s.m2m)
            begin
              next_s.half = 1'b0;
              next_s.phase = ST_UPPER;
            end
            else if (next_addr[15:8] != s.cur_addr[src][15:8])
            begin
              next_s.phase = ST_UPPER;
            end
            else
            begin
              next_s.phase = ST_ADDR;
            end
          end
        end
      end
      default: next_s.phase = ST_IDLE;
    endcase

    // Pin outputs follow the next phase so that they leave a flip-flop
    active = (next_s.phase >= ST_UPPER);
    src = next_s.m2m ? {1'b0, next_s.half} : next_s.chan;
    xtype = next_s.mode[next_s.chan][1:0];
    next_s.addr_enable = active;
    next_s.addr_oe = active;
    next_s.io_oe = active;
    next_s.upper_addr_strobe = (next_s.phase == ST_UPPER);
    next_s.addr_lo = active ? next_s.cur_addr[src][7:0] : 8'h00;
    // Verify matches neither type, so every strobe stays high
    next_s.mem_rd_b = !(((next_s.phase == ST_EXTEND) || (next_s.phase == ST_XFER)) &&
                        (next_s.m2m ? !next_s.half : (xtype == TYPE_READ)));
    next_s.io_rd_b = !(((next_s.phase == ST_EXTEND) || (next_s.phase == ST_XFER)) &&
                       !next_s.m2m && (xtype == TYPE_WRITE));
    next_s.mem_wr_b = !((next_s.phase == ST_XFER) &&
                        (next_s.m2m ? next_s.half : (xtype == TYPE_WRITE)));
    next_s.io_wr_b = !((next_s.phase == ST_XFER) && !next_s.m2m &&
                       (xtype == TYPE_READ));
    if (next_s.phase == ST_UPPER)
    begin
      next_s.dout = next_s.cur_addr[src][15:8];
      next_s.dout_oe = 1'b1;
    end
    else if (active)
    begin
      next_s.dout = next_s.temp;
      next_s.dout_oe = next_s.m2m && next_s.half;
    end
    else
    begin
      // Base registers have no read path
      next_s.dout = !reg_addr[3] ? (next_s.byte_ptr ? rd_word[15:8] : rd_word[7:0]) :
                    (reg_addr == OFS_TEMP_READ) ? s.temp : 8'h00;
      next_s.dout_oe = program_cond && !s.sync2[SY_IOR];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s <= '0;
      s.phase <= ST_IDLE;
      s.command <= COMMAND_RST;
      s.request <= REQUEST_RST;
      s.mask <= MASK_RST;
      s.last <= LAST_RST;
      s.sync1 <= SYNC_RST;
      s.sync2 <= SYNC_RST;
      s.prev <= SYNC_RST;
      s.mem_rd_b <= 1'b1;
      s.mem_wr_b <= 1'b1;
      s.io_rd_b <= 1'b1;
      s.io_wr_b <= 1'b1;
    end
    else if (ce_in)
    begin
      s <= next_s;
    end
  end

  assign data_out = s.dout;
  assign data_oe_out = s.dout_oe;
  assign io_read_strobe_b_out = s.io_rd_b;
  assign io_read_strobe_oe_out = s.io_oe;
  assign io_write_strobe_b_out = s.io_wr_b;
  assign io_write_strobe_oe_out = s.io_oe;
  assign mem_read_strobe_b_out = s.mem_rd_b;
  assign mem_write_strobe_b_out = s.mem_wr_b;
  assign addr_low_out = s.addr_lo;
  assign addr_low_oe_out = s.addr_oe;
  assign addr_enable_out = s.addr_enable;
  assign upper_addr_strobe_out = s.upper_addr_strobe;
  assign channel_acknowledge_out = s.channel_acknowledge;
  assign hold_request_out = s.hold_req;
  assign end_of_process_b_out = s.eop_level;
  assign end_of_process_oe_out = s.eop_drive;
  assign terminal_count_out = s.tc;
endmodule

// ===== testbench.sv
// Self-checking bench of the DMA transfer core with random block services.
// Assumes the package, core, far-side model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import dma_core_pkg::*;
  logic clk_in = 0, rst_b_in = 0, chip_select_b_in = 1, host_ior_b = 1, host_iow_b = 1;
  logic [3:0] reg_addr_in = 0, channel_request_in = 0, lag = 0, first_ack;
  logic [7:0] host_din = 0, mem_data, data_out, addr_low_out, last_data;
  logic [15:0] strobes, writes, last_addr;
  logic [3:0] channel_acknowledge_out;
  logic data_oe_out, io_read_strobe_b_out, io_read_strobe_oe_out, io_write_strobe_b_out;
  logic io_write_strobe_oe_out, mem_read_strobe_b_out, mem_write_strobe_b_out;
  logic addr_low_oe_out, addr_enable_out, upper_addr_strobe_out, hold_request_out;
  logic hold_acknowledge_in, end_of_process_b_out, end_of_process_oe_out, terminal_count_out;
  wire logic [7:0] data_in = mem_read_strobe_b_out ? host_din : mem_data;
  wire logic io_read_strobe_b_in = io_read_strobe_oe_out ? io_read_strobe_b_out : host_ior_b;
  wire logic io_write_strobe_b_in = io_write_strobe_oe_out ? io_write_strobe_b_out : host_iow_b;
  // Pulled up; only the core pulls it low
  wire logic end_of_process_b_in = !end_of_process_oe_out;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #5 clk_in = ~clk_in;
  four_channel_dma_transfer_core uut (.clk_in, .rst_b_in, .ce_in(1'b1), .chip_select_b_in,
    .reg_addr_in, .data_in, .data_out, .data_oe_out, .io_read_strobe_b_in,
    .io_read_strobe_b_out, .io_read_strobe_oe_out, .io_write_strobe_b_in,
    .io_write_strobe_b_out, .io_write_strobe_oe_out, .mem_read_strobe_b_out,
    .mem_write_strobe_b_out, .addr_low_out, .addr_low_oe_out, .addr_enable_out,
    .upper_addr_strobe_out, .channel_request_in, .channel_acknowledge_out,
    .hold_request_out, .hold_acknowledge_in, .end_of_process_b_in, .end_of_process_b_out,
    .end_of_process_oe_out, .terminal_count_out);
  bus_partner far_end (.clk_in, .rst_b_in, .lag_in(lag), .hold_request_in(hold_request_out),
    .hold_acknowledge_out(hold_acknowledge_in), .upper_addr_strobe_in(upper_addr_strobe_out),
    .data_bus_in(data_out), .addr_low_in(addr_low_out), .mem_write_b_in(mem_write_strobe_b_out),
    .ack_in(channel_acknowledge_out), .mem_data_out(mem_data), .strobes_out(strobes),
    .writes_out(writes), .last_addr_out(last_addr), .last_data_out(last_data),
    .first_ack_out(first_ack));
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes held well past the three-clock synchroniser latency
  task wr(input logic [3:0] a, input logic [7:0] d);
    chip_select_b_in = 0;
    reg_addr_in = a;
    host_din = d;
    cyc(1);
    host_iow_b = 0;
    cyc(4);
    host_iow_b = 1;
    cyc(5);
    chip_select_b_in = 1;
    cyc(1);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    chip_select_b_in = 0;
    reg_addr_in = a;
    cyc(1);
    host_ior_b = 0;
    cyc(5);
    d = data_out;
    host_ior_b = 1;
    cyc(5);
    chip_select_b_in = 1;
    cyc(1);
  endtask
  task wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask
  task rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
  endtask
  // Requests are dropped once acknowledged, as a block-mode peripheral may
  task wait_tc;
    int k;
    k = 0;
    while (terminal_count_out !== 1'b1 && k < 3000)
    begin
      channel_request_in = channel_request_in & ~channel_acknowledge_out;
      cyc(1);
      k++;
    end
    if (k == 3000)
    begin
      miscompares++;
      $display("ERROR %0t: no terminal count", $time);
    end
    cyc(1);
  endtask
  function automatic logic [15:0] ups(logic [15:0] a, logic [3:0] n, logic dec);
    logic [15:0] c;
    c = 1;
    for (int k = 0; k < n; k++)
    begin
      c += 16'((dec ? a - 16'h0001 : a + 16'h0001) >> 8 != a >> 8);
      a = dec ? a - 16'h0001 : a + 16'h0001;
    end
    return c;
  endfunction
  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    logic [15:0] ad, v;
    logic [1:0] ch;
    logic dec, auto;
    logic [3:0] n;
    ad = 16'($urandom(17));
    cyc(6);
    rst_b_in = 1;
    cyc(2);
    for (int i = 0; i < 8; i++)
    begin
      ch = 2'($urandom % 4);
      dec = i[2];
      auto = (i == 5);
      n = 4'($urandom % 5);
      lag = 4'($urandom % 8);
      ad = dec ? 16'h0100 + 16'($urandom % 3) : 16'h00FC + 16'($urandom % 4);
      wr(4'hC, 8'h00);
      wr16({1'b0, ch, 1'b0}, ad);
      wr16({1'b0, ch, 1'b1}, {12'h000, n});
      rd16({1'b0, ch, 1'b0}, v);
      check(v, ad);
      wr(4'hB, {2'b10, dec, auto, 2'(i % 3), ch});
      wr(4'h8, {4'h0, 1'($urandom % 2), 3'h0});
      wr(4'hF, 8'h00);
      v = strobes;
      channel_request_in[ch] = 1;
      wait_tc();
      cyc(4);
      check(strobes - v, ups(ad, n, dec));
      rd16({1'b0, ch, 1'b1}, v);
      check(v, auto ? {12'h000, n} : 16'hFFFF);
      rd16({1'b0, ch, 1'b0}, v);
      check(v, auto ? ad : dec ? ad - 16'(n) - 16'h0001 : ad + 16'(n) + 16'h0001);
      // Masked unless autoinitialized; looked at before a short re-service can end
      channel_request_in[ch] = 1'b1;
      cyc(5);
      check(16'(hold_request_out), 16'(auto));
      if (auto)
        wait_tc();
      channel_request_in = 0;
      $display("service test %0d done", i);
    end
    for (int r = 0; r < 2; r++)
    begin
      wr(4'h8, {3'h0, r[0], 4'h0});
      wr(4'hC, 8'h00);
      for (int c = 0; c < 4; c += 3)
      begin
        wr16({1'b0, 2'(c), 1'b1}, 16'h0000);
        wr(4'hB, {6'b100001, 2'(c)});
      end
      wr(4'hF, 8'h00);
      channel_request_in = 4'h1;
      wait_tc();
      cyc(4);
      // Channel 0 count wrapped to all ones; reload it for a single transfer
      wr16(4'h1, 16'h0000);
      wr(4'hF, 8'h00);
      channel_request_in = 4'h9;
      wait_tc();
      check(16'(first_ack), r ? 16'h0008 : 16'h0001);
      wait_tc();
      cyc(4);
      $display("priority test %0d done", r);
    end
    for (int f = 0; f < 2; f++)
    begin
      n = 4'(2 + $urandom % 4);
      ad = 16'h0040 + 16'($urandom % 64);
      wr(4'hF, 8'h03);
      wr(4'hC, 8'h00);
      wr16(4'h0, ad);
      wr16(4'h1, {12'h000, n});
      wr16(4'h2, 16'h0200);
      wr16(4'h3, {12'h000, n});
      wr(4'hB, 8'h88);
      wr(4'hB, 8'h89);
      wr(4'h8, {6'h00, f[0], 1'b1});
      v = writes;
      wr(4'h9, 8'h04);
      wait_tc();
      cyc(4);
      check(writes - v, 16'(n) + 16'h0001);
      check(last_addr, 16'h0200 + 16'(n));
      check(16'(last_data), 16'((f ? ad[7:0] : ad[7:0] + 8'(n)) ^ 8'h5A));
      rd16(4'h3, v);
      check(v, 16'hFFFF);
      $display("memory move test %0d done", f);
    end
    test_done();
  end
endmodule
bind four_channel_dma_transfer_core dma_core_chk chk_i (.clk_in, .rst_b_in, .data_oe_out,
  .io_read_strobe_b_out, .io_read_strobe_oe_out, .io_write_strobe_b_out,
  .io_write_strobe_oe_out, .mem_read_strobe_b_out, .mem_write_strobe_b_out, .addr_low_oe_out,
  .addr_enable_out, .upper_addr_strobe_out, .channel_acknowledge_out, .hold_request_out,
  .hold_acknowledge_in, .end_of_process_oe_out, .terminal_count_out);
